/* File: src/ntb_endpoint_intr_pm_cfg_regs.sv */
`timescale 1ns/1ns
module ntb_endpoint_intr_pm_cfg_regs
    import ntb_cfg_pkg::*;
(
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_b,
    // configuration request
    input  wire logic                 cfgReq,
    input  wire logic                 cfgWrite,
    input  wire logic [11:0]          cfgAddr,
    input  wire logic [3:0]           cfgByteEn,
    input  wire logic [31:0]          cfgWrData,
    // configuration answer
    output logic                      cfgAck,
    output logic      [31:0]          cfgRdData,
    // state of neighbouring configuration logic
    input  wire logic                 msiEnable,
    input  wire logic                 legacyIrqDisable,
    input  wire logic                 regLockActive,
    // event sources
    input  wire logic                 doorbellPending,
    input  wire logic                 farResetDetected,
    input  wire logic                 farPowerChanged,
    input  wire logic                 portALinkUp,
    // interrupt message requests
    output logic                      msiRequest,
    output logic      [TC_W-1:0]      msiTrafficClass,
    output logic      [NUM_LINES-1:0] intxAssert,
    output logic      [NUM_LINES-1:0] intxDeassert,
    // power state toward the bridge core
    output logic      [POWER_STATE_FIELD_W-1:0]  powerState,
    output logic                      powerStateModified
);

    // writable fields
    logic [ACT_W-1:0]    doorbellActFf;
    logic [ACT_W-1:0]    farResetActFf;
    logic [ACT_W-1:0]    farPowerActFf;
    logic [ACT_W-1:0]    portAUpActFf;
    logic [TC_W-1:0]     trafficClassFf;
    logic                specialInitFf;
    logic [POWER_STATE_FIELD_W-1:0] powerStateFf;
    logic                pstateModFf;
    logic [IND_W-1:0]    indAddrFf;
    logic [31:0]         bridgeCfgFf;
    logic                ackFf;
    logic [31:0]         rdDataFf;

    // status from the event block
    logic [NUM_EVENTS-1:0] statusBits;
    logic [NUM_EVENTS-1:0] clearMask;

    // decode
    logic        viaIndirect;
    logic [11:0] effAddr;
    logic        selfTarget;
    logic        wrStrobe;
    logic        rdStrobe;
    logic        hitStatus;
    logic        hitBridgeIrq;
    logic        hitPmCap;
    logic        hitPmCsr;
    logic        hitIndAddr;
    logic        hitBridgeCfg;
    logic        hitLinkIrq;
    logic [31:0] statusWord;
    logic [31:0] bridgeIrqWord;
    logic [31:0] pmCapWord;
    logic [31:0] pmCsrWord;
    logic [31:0] indAddrWord;
    logic [31:0] linkIrqWord;
    logic [31:0] readWord;
    logic [31:0] newBridgeIrq;
    logic [31:0] newPmCap;
    logic [31:0] newPmCsr;
    logic [31:0] newIndAddr;
    logic [31:0] newBridgeCfg;
    logic [31:0] newLinkIrq;
    logic        pstateLegal;

    // the data register forwards to the selected register
    assign viaIndirect = (cfgAddr == OFS_IND_DATA);
    assign effAddr     = viaIndirect ?
                         {indAddrFf, 2'b00} : cfgAddr;
    // data pointing at itself: reads zero, writes dropped
    assign selfTarget  = viaIndirect &&
                         (effAddr == OFS_IND_DATA);
    assign wrStrobe    = cfgReq & cfgWrite & ~selfTarget;
    assign rdStrobe    = cfgReq & ~cfgWrite;

    // register hits on the effective address; pointing at the
    // address register lets a data write rewrite it
    assign hitStatus    = wrStrobe && (effAddr == OFS_EVENT_STATUS);
    assign hitBridgeIrq = wrStrobe && (effAddr == OFS_BRIDGE_IRQ);
    assign hitPmCap     = wrStrobe && (effAddr == OFS_PM_CAP);
    assign hitPmCsr     = wrStrobe && (effAddr == OFS_PM_CSR);
    assign hitIndAddr   = wrStrobe &&
                          (effAddr == OFS_IND_ADDR);
    assign hitBridgeCfg = wrStrobe && (effAddr == OFS_BRIDGE_CFG);
    assign hitLinkIrq   = wrStrobe && (effAddr == OFS_LINK_IRQ);

    // readback images; unimplemented bits are zero
    assign statusWord    = {{(32-STS_LSB-NUM_EVENTS){1'b0}},
                            statusBits, {STS_LSB{1'b0}}};
    assign bridgeIrqWord = {trafficClassFf, 8'h00,
                            farPowerActFf, farResetActFf,
                            doorbellActFf, 12'h000};
    // pme support, d2, d1 and aux current all read zero
    assign pmCapWord     = {5'h00, 1'b0, 1'b0, 3'h0, specialInitFf,
                            1'b0, 1'b0, PM_VERSION, PM_NEXT_PTR,
                            PM_CAP_ID};
    // pme enable and status stay zero, no pm events are generated
    assign pmCsrWord     = {30'h0000_0000, powerStateFf};
    assign indAddrWord   = {20'h00000, indAddrFf, 2'b00};
    assign linkIrqWord   = {29'h0000_0000, portAUpActFf};

    // read mux; extended header and unmapped offsets read zero
    assign readWord =
        selfTarget                      ? RST_WORD :
        (effAddr == OFS_EVENT_STATUS)   ? statusWord :
        (effAddr == OFS_BRIDGE_IRQ)     ? bridgeIrqWord :
        (effAddr == OFS_PM_CAP)         ? pmCapWord :
        (effAddr == OFS_PM_CSR)         ? pmCsrWord :
        (effAddr == OFS_IND_ADDR)       ? indAddrWord :
        (effAddr == OFS_EXT_CAP)        ? RST_WORD :
        (effAddr == OFS_BRIDGE_CFG)     ? bridgeCfgFf :
        (effAddr == OFS_LINK_IRQ)       ? linkIrqWord :
                                          RST_WORD;

    // byte-enabled merges of the write data
    assign newBridgeIrq = merge_bytes(bridgeIrqWord, cfgWrData,
                                      cfgByteEn);
    assign newPmCap     = merge_bytes(pmCapWord, cfgWrData, cfgByteEn);
    assign newPmCsr     = merge_bytes(pmCsrWord, cfgWrData, cfgByteEn);
    assign newIndAddr   = merge_bytes(indAddrWord, cfgWrData, cfgByteEn);
    assign newBridgeCfg = merge_bytes(bridgeCfgFf, cfgWrData, cfgByteEn);
    assign newLinkIrq   = merge_bytes(linkIrqWord, cfgWrData, cfgByteEn);

    // write-one clears only the sticky bits in the low byte lane
    assign clearMask = (hitStatus && cfgByteEn[0]) ?
        cfgWrData[STS_LSB +: NUM_EVENTS] : '0;

    // d1 and d2 are not supported, such writes keep the old state
    assign pstateLegal = (newPmCsr[POWER_STATE_FIELD_W-1:0] == POWER_STATE_FIELD_D0) ||
                         (newPmCsr[POWER_STATE_FIELD_W-1:0] == POWER_STATE_FIELD_D3);

    // interrupt control fields
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            doorbellActFf  <= ACT_MASKED;
            farResetActFf  <= ACT_MASKED;
            farPowerActFf  <= ACT_MASKED;
            portAUpActFf   <= ACT_MASKED;
            trafficClassFf <= '0;
        end else begin
            if (hitBridgeIrq) begin
                doorbellActFf  <= newBridgeIrq[ACT_DOORBELL +: ACT_W];
                farResetActFf  <= newBridgeIrq[ACT_FAR_RESET +: ACT_W];
                farPowerActFf  <= newBridgeIrq[ACT_FAR_POWER +: ACT_W];
                trafficClassFf <= newBridgeIrq[TC_LSB +: TC_W];
            end
            if (hitLinkIrq) begin
                portAUpActFf <= newLinkIrq[ACT_PORT_A_UP +: ACT_W];
            end
        end
    end

    // power management fields; the lock freezes the init flag
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            specialInitFf <= 1'b0;
            powerStateFf  <= POWER_STATE_FIELD_D0;
            pstateModFf   <= 1'b0;
        end else begin
            if (hitPmCap && !regLockActive) begin
                specialInitFf <= newPmCap[PM_SPECIAL_INIT_FLAG_BIT];
            end
            if (hitPmCsr && pstateLegal) begin
                powerStateFf <= newPmCsr[POWER_STATE_FIELD_W-1:0];
            end
            pstateModFf <= hitPmCsr && pstateLegal && cfgByteEn[0];
        end
    end

    // indirect address and the plain bridge configuration word
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            indAddrFf   <= '0;
            bridgeCfgFf <= RST_WORD;
        end else begin
            if (hitIndAddr) begin
                indAddrFf <= newIndAddr[IND_LSB +: IND_W];
            end
            if (hitBridgeCfg) begin
                bridgeCfgFf <= newBridgeCfg;
            end
        end
    end

    // every request is answered one cycle later, writes with zero data
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ackFf    <= 1'b0;
            rdDataFf <= RST_WORD;
        end else begin
            ackFf    <= cfgReq;
            rdDataFf <= rdStrobe ? readWord : RST_WORD;
        end
    end

    // status bits for the four events
    event_status_bits u_status (
        .core_clk         (core_clk),
        .rst_b            (rst_b),
        .doorbellPending  (doorbellPending),
        .farResetDetected (farResetDetected),
        .farPowerChanged  (farPowerChanged),
        .portALinkUp      (portALinkUp),
        .clearMask        (clearMask),
        .statusBits       (statusBits)
    );

    // action selection; codes follow the event index order
    irq_dispatch u_dispatch (
        .core_clk         (core_clk),
        .rst_b            (rst_b),
        .statusBits       (statusBits),
        .actionCodes      ({portAUpActFf, farPowerActFf,
                            farResetActFf, doorbellActFf}),
        .msiEnable        (msiEnable),
        .legacyIrqDisable (legacyIrqDisable),
        .msiRequest       (msiRequest),
        .intxAssert       (intxAssert),
        .intxDeassert     (intxDeassert)
    );

    assign cfgAck             = ackFf;
    assign cfgRdData          = rdDataFf;
    assign msiTrafficClass    = trafficClassFf;
    assign powerState         = powerStateFf;
    assign powerStateModified = pstateModFf;

endmodule // ntb_endpoint_intr_pm_cfg_regs

/* File: common/ntb_cfg_pkg.sv */
package ntb_cfg_pkg;

    // configuration space byte offsets (dword aligned)
    localparam logic [11:0] OFS_EVENT_STATUS = 12'h0E8;
    localparam logic [11:0] OFS_BRIDGE_IRQ   = 12'h0EC;
    localparam logic [11:0] OFS_PM_CAP       = 12'h0F0;
    localparam logic [11:0] OFS_PM_CSR       = 12'h0F4;
    localparam logic [11:0] OFS_IND_ADDR     = 12'h0F8;
    localparam logic [11:0] OFS_IND_DATA     = 12'h0FC;
    localparam logic [11:0] OFS_EXT_CAP      = 12'h100;
    localparam logic [11:0] OFS_BRIDGE_CFG   = 12'h200;
    localparam logic [11:0] OFS_LINK_IRQ     = 12'h210;

    // event indices, also the order of packed action codes
    localparam int NUM_EVENTS   = 4;
    localparam int NUM_LINES    = 4;
    localparam int EV_DOORBELL  = 0;
    localparam int EV_FAR_RESET = 1;
    localparam int EV_FAR_POWER = 2;
    localparam int EV_PORT_A_UP = 3;

    // event status register field positions
    localparam int STS_LSB = 4;

    // interrupt control field positions
    localparam int ACT_W          = 3;
    localparam int ACT_DOORBELL   = 12;
    localparam int ACT_FAR_RESET  = 15;
    localparam int ACT_FAR_POWER  = 18;
    localparam int ACT_PORT_A_UP  = 0;
    localparam int TC_LSB         = 29;
    localparam int TC_W           = 3;

    // interrupt action encoding
    typedef enum logic [ACT_W-1:0] {
        ACT_MASKED = 3'h0,
        ACT_MSI    = 3'h1,
        ACT_INTA   = 3'h2,
        ACT_INTB   = 3'h3,
        ACT_INTC   = 3'h4,
        ACT_INTD   = 3'h5
    } irq_action_t;

    // power management capability header
    localparam logic [7:0] PM_CAP_ID      = 8'h01;
    localparam logic [7:0] PM_NEXT_PTR    = 8'h00;
    localparam logic [2:0] PM_VERSION     = 3'h2;
    localparam int         PM_SPECIAL_INIT_FLAG_BIT   = 21;

    // power state field
    localparam int         POWER_STATE_FIELD_W   = 2;
    localparam logic [1:0] POWER_STATE_FIELD_D0  = 2'h0;
    localparam logic [1:0] POWER_STATE_FIELD_D3  = 2'h3;

    // indirect address: register number 7:2, extended number 11:8
    localparam int IND_LSB = 2;
    localparam int IND_W   = 10;

    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // merge write data into an old word under byte enables
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] oldWord,
        input logic [31:0] newWord,
        input logic [3:0]  byteEn
    );
        logic [31:0] res;
        res = oldWord;
        for (int b = 0; b < 4; b++) begin
            if (byteEn[b]) begin
                res[b*8 +: 8] = newWord[b*8 +: 8];
            end
        end
        return res;
    endfunction

endpackage

/* File: src/event_status_bits.sv */
`timescale 1ns/1ns
module event_status_bits
    import ntb_cfg_pkg::*;
(
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst_b,
    // event sources
    input  wire logic                  doorbellPending,
    input  wire logic                  farResetDetected,
    input  wire logic                  farPowerChanged,
    input  wire logic                  portALinkUp,
    // write-one-to-clear strobes
    input  wire logic [NUM_EVENTS-1:0] clearMask,
    // status
    output logic      [NUM_EVENTS-1:0] statusBits
);

    logic                  linkUpPrevFf;
    logic [NUM_EVENTS-1:0] statusFf;
    logic [NUM_EVENTS-1:0] nxt_status;
    logic                  linkUpRise;

    // link up counts only on a down-to-up transition
    assign linkUpRise = portALinkUp & ~linkUpPrevFf;

    // set wins over a clear in the same cycle
    assign nxt_status[EV_DOORBELL]  = doorbellPending;
    assign nxt_status[EV_FAR_RESET] = farResetDetected |
        (statusFf[EV_FAR_RESET] & ~clearMask[EV_FAR_RESET]);
    assign nxt_status[EV_FAR_POWER] = farPowerChanged |
        (statusFf[EV_FAR_POWER] & ~clearMask[EV_FAR_POWER]);
    assign nxt_status[EV_PORT_A_UP] = linkUpRise |
        (statusFf[EV_PORT_A_UP] & ~clearMask[EV_PORT_A_UP]);

    // status flops
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            statusFf     <= '0;
            linkUpPrevFf <= 1'b0;
        end else begin
            statusFf     <= nxt_status;
            linkUpPrevFf <= portALinkUp;
        end
    end

    assign statusBits = statusFf;

endmodule // event_status_bits

/* File: src/irq_dispatch.sv */
`timescale 1ns/1ns
module irq_dispatch
    import ntb_cfg_pkg::*;
(
    // clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        rst_b,
    // events and their actions
    input  wire logic [NUM_EVENTS-1:0]       statusBits,
    input  wire logic [NUM_EVENTS*ACT_W-1:0] actionCodes,
    // gating from the command and msi capability
    input  wire logic                        msiEnable,
    input  wire logic                        legacyIrqDisable,
    // message requests
    output logic                             msiRequest,
    output logic      [NUM_LINES-1:0]        intxAssert,
    output logic      [NUM_LINES-1:0]        intxDeassert
);

    logic [NUM_EVENTS-1:0] prevStatusFf;
    logic [NUM_EVENTS-1:0] msiFire;
    logic [NUM_LINES-1:0]  lineHit [NUM_EVENTS];
    logic [NUM_LINES-1:0]  wantLine;
    logic [NUM_LINES-1:0]  lineFf;
    logic                  msiFf;
    logic [NUM_LINES-1:0]  assertFf;
    logic [NUM_LINES-1:0]  deassertFf;

    // per-event action decode; reserved codes select nothing
    for (genvar e = 0; e < NUM_EVENTS; e++) begin : g_event
        irq_action_t act;
        assign act = irq_action_t'(actionCodes[e*ACT_W +: ACT_W]);
        // msi only on the status bit going from clear to set
        assign msiFire[e] = statusBits[e] & ~prevStatusFf[e] &
                            (act == ACT_MSI);
        assign lineHit[e] = {statusBits[e] & (act == ACT_INTD),
                             statusBits[e] & (act == ACT_INTC),
                             statusBits[e] & (act == ACT_INTB),
                             statusBits[e] & (act == ACT_INTA)};
    end

    // a shared line stays asserted while any of its events is set
    always_comb begin
        wantLine = '0;
        for (int e = 0; e < NUM_EVENTS; e++) begin
            wantLine = wantLine | lineHit[e];
        end
        if (legacyIrqDisable) begin
            wantLine = '0;
        end
    end

    // edges of the virtual wire become assert and deassert messages;
    // disabling legacy interrupts therefore also negates open lines
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prevStatusFf <= '0;
            lineFf       <= '0;
            msiFf        <= 1'b0;
            assertFf     <= '0;
            deassertFf   <= '0;
        end else begin
            prevStatusFf <= statusBits;
            lineFf       <= wantLine;
            msiFf        <= (|msiFire) & msiEnable;
            assertFf     <= wantLine & ~lineFf;
            deassertFf   <= ~wantLine & lineFf;
        end
    end

    assign msiRequest   = msiFf;
    assign intxAssert   = assertFf;
    assign intxDeassert = deassertFf;

endmodule // irq_dispatch

/* File: tb/cfg_host_model.sv */
`timescale 1ns/1ns
module cfg_host_model
    import ntb_cfg_pkg::*;
(
    // clock
    input  wire logic        core_clk,
    // answer
    input  wire logic        cfgAck,
    input  wire logic [31:0] cfgRdData,
    // request
    output logic             cfgReq,
    output logic             cfgWrite,
    output logic [11:0]      cfgAddr,
    output logic [3:0]       cfgByteEn,
    output logic [31:0]      cfgWrData
);
    // idle request lines at time zero
    initial begin
        cfgReq = 1'b0;
        cfgWrite = 1'b0;
        cfgAddr = 12'h0;
        cfgByteEn = 4'h0;
        cfgWrData = 32'h0;
    end

    // one dword access from just after an edge, then a spare cycle
    task automatic access(input logic wr, input logic [11:0] adr,
        input logic [3:0] be, input logic [31:0] wd,
        output logic [31:0] rd);
        cfgReq = 1'b1;
        cfgWrite = wr;
        cfgAddr = adr;
        cfgByteEn = be;
        cfgWrData = wd;
        @(posedge core_clk);
        #1;
        rd = cfgRdData;
        cfgReq = 1'b0;
        // released lines show the inverse
        cfgWrite = ~wr;
        cfgAddr = ~adr;
        cfgByteEn = ~be;
        cfgWrData = ~wd;
        @(posedge core_clk);
        #1;
    endtask
endmodule // cfg_host_model

/* File: tb/ntb_endpoint_intr_pm_cfg_regs_chk.sv */
`timescale 1ns/1ns
module ntb_endpoint_intr_pm_cfg_regs_chk
    import ntb_cfg_pkg::*;
(
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst_b,
    // configuration port
    input wire logic        cfgReq,
    input wire logic        cfgWrite,
    input wire logic [3:0]  cfgByteEn,
    input wire logic        cfgAck,
    input wire logic [31:0] cfgRdData,
    // gating and messages
    input wire logic        msiEnable,
    input wire logic        legacyIrqDisable,
    input wire logic        msiRequest,
    input wire logic [2:0]  msiTrafficClass,
    input wire logic [3:0]  intxAssert,
    input wire logic [3:0]  intxDeassert,
    input wire logic [1:0]  powerState,
    input wire logic        powerStateModified
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // one answer per request, one cycle later
    ack_after_req_a: assert property (cfgReq |=> cfgAck)
        else $error("request without answer");
    ack_has_req_a: assert property (cfgAck |-> $past(cfgReq))
        else $error("answer without request");
    quiet_data_a: assert property (!cfgAck |-> cfgRdData == 32'h0)
        else $error("read data outside an answer");
    write_data_a: assert property (cfgReq && cfgWrite |=> cfgRdData == 32'h0)
        else $error("write answered with data");
    // messages gated by enables a cycle earlier
    msi_gate_a: assert property (msiRequest |-> $past(msiEnable))
        else $error("msi while msi disabled");
    intx_gate_a: assert property (|intxAssert |-> !$past(legacyIrqDisable))
        else $error("legacy assert while disabled");
    // power state legal, moved only by writes
    power_state_field_legal_a: assert property (powerState != 2'h1 && powerState != 2'h2)
        else $error("reserved power state");
    power_state_field_cause_a: assert property ($changed(powerState) |-> $past(cfgReq && cfgWrite))
        else $error("power state moved without write");
    power_state_field_pulse_a: assert property (powerStateModified |-> $past(cfgReq && cfgWrite && cfgByteEn[0]))
        else $error("modify pulse without write");
    tc_cause_a: assert property ($changed(msiTrafficClass) |-> $past(cfgReq && cfgWrite))
        else $error("traffic class moved without write");

    // main scenarios reached
    msi_seen_c: cover property (msiRequest);
    intx_on_c: cover property (|intxAssert);
    intx_off_c: cover property (|intxDeassert);
    power_state_field_mod_c: cover property (powerStateModified);
endmodule // ntb_endpoint_intr_pm_cfg_regs_chk

bind ntb_endpoint_intr_pm_cfg_regs ntb_endpoint_intr_pm_cfg_regs_chk i_chk (
    .core_clk, .rst_b, .cfgReq, .cfgWrite, .cfgByteEn, .cfgAck, .cfgRdData,
    .msiEnable, .legacyIrqDisable, .msiRequest, .msiTrafficClass,
    .intxAssert, .intxDeassert, .powerState, .powerStateModified);

/* File: tb/ntb_endpoint_intr_pm_cfg_regs_bench.sv */
`timescale 1ns/1ns
module ntb_endpoint_intr_pm_cfg_regs_bench;
    import ntb_cfg_pkg::*;
    typedef struct packed {
        logic [11:0] adr; logic [3:0] be; logic [31:0] wd; logic [31:0] ex;
    } row_t;
    // write, then read back what should stick
    localparam row_t ROWS [10] = '{
        '{12'h0F0, 4'hF, 32'hFFFF_FFFF, 32'h0022_0001},
        '{12'h0F0, 4'hF, 32'h0, 32'h0002_0001},
        '{12'h0F4, 4'hF, 32'hFFFF_FFFF, 32'h3},
        '{12'h0F4, 4'h1, 32'h1, 32'h3},
        '{12'h0F8, 4'hF, 32'hFFFF_FFFF, 32'hFFC},
        '{12'h100, 4'hF, 32'hFFFF_FFFF, 32'h0},
        '{12'h0EC, 4'hF, 32'hFFEE_5FFF, 32'hE00E_5000},
        '{12'h210, 4'hF, 32'hFFFF_FFFD, 32'h5},
        '{12'h200, 4'h5, 32'hA5A5_5A5A, 32'h00A5_005A},
        '{12'h300, 4'hF, 32'hFFFF_FFFF, 32'h0}};
    logic core_clk = 1'b0, rst_b = 1'b0, msiEnable = 1'b1;
    logic legacyIrqDisable = 1'b0, regLockActive = 1'b0;
    logic doorbellPending = 1'b0, farResetDetected = 1'b0;
    logic farPowerChanged = 1'b0, portALinkUp = 1'b0;
    logic cfgReq, cfgWrite, cfgAck, msiRequest, powerStateModified;
    logic [11:0] cfgAddr;
    logic [3:0] cfgByteEn, intxAssert, intxDeassert, msiCnt, modCnt;
    logic [31:0] cfgWrData, cfgRdData, rdv;
    logic [2:0] msiTrafficClass;
    logic [1:0] powerState;
    logic [15:0] astCnt, deaCnt;
    int checks = 0, miscompares = 0, cycles = 0;

    always #5 core_clk = ~core_clk;

    ntb_endpoint_intr_pm_cfg_regs i_dut (.core_clk, .rst_b, .cfgReq,
        .cfgWrite, .cfgAddr, .cfgByteEn, .cfgWrData, .cfgAck, .cfgRdData,
        .msiEnable, .legacyIrqDisable, .regLockActive, .doorbellPending,
        .farResetDetected, .farPowerChanged, .portALinkUp, .msiRequest,
        .msiTrafficClass, .intxAssert, .intxDeassert, .powerState,
        .powerStateModified);
    cfg_host_model host (.core_clk, .cfgAck, .cfgRdData, .cfgReq,
        .cfgWrite, .cfgAddr, .cfgByteEn, .cfgWrData);

    // tally pulses; the ceiling cuts off a hang
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        msiCnt <= msiCnt + 4'(msiRequest === 1'b1);
        modCnt <= modCnt + 4'(powerStateModified === 1'b1);
        for (int l = 0; l < 4; l++) begin
            astCnt[4*l +: 4] <= astCnt[4*l +: 4] + 4'(intxAssert[l] === 1'b1);
            deaCnt[4*l +: 4] <= deaCnt[4*l +: 4] + 4'(intxDeassert[l] === 1'b1);
        end
        if (cycles == 5000) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic chk_reg(string nm, logic [31:0] ex, logic [31:0] got);
        checks++;
        if (got !== ex) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic chk_cnt(string nm, logic [15:0] ex, logic [15:0] got);
        checks++;
        if (got !== ex) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic wr(logic [11:0] a, logic [3:0] be, logic [31:0] d);
        host.access(1'b1, a, be, d, rdv);
    endtask
    task automatic rd(logic [11:0] a);
        host.access(1'b0, a, 4'hF, 32'h0, rdv);
    endtask
    task automatic wait_cy(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic clr();
        msiCnt = 4'h0;
        modCnt = 4'h0;
        astCnt = 16'h0;
        deaCnt = 16'h0;
    endtask
    task automatic complete_run();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        clr();
        wait_cy(16);
        rst_b = 1'b1;
        wait_cy(1);
        foreach (ROWS[i]) begin
            wr(ROWS[i].adr, ROWS[i].be, ROWS[i].wd);
            rd(ROWS[i].adr);
            chk_reg("row", ROWS[i].ex, rdv);
        end
        $display("test register rows finished");
        // doorbell through every legal code, set while idle
        for (int a = 0; a < 6; a++) begin
            wr(12'h0EC, 4'hF, 32'hA000_0000 | (32'(a) << 12));
            clr();
            doorbellPending = 1'b1;
            wait_cy(4);
            rd(12'h0E8);
            chk_reg("doorbell status", 32'h10, rdv);
            doorbellPending = 1'b0;
            wait_cy(4);
            chk_cnt("msi", 16'(a == 1), {12'h0, msiCnt});
            chk_cnt("assert", a > 1 ? 16'h1 << 4*(a-2) : 16'h0, astCnt);
            chk_cnt("deassert", a > 1 ? 16'h1 << 4*(a-2) : 16'h0, deaCnt);
        end
        chk_reg("tc", 32'h5, {29'h0, msiTrafficClass});
        clr();
        msiEnable = 1'b0;
        wr(12'h0EC, 4'hF, 32'h0000_1000);
        doorbellPending = 1'b1;
        wait_cy(4);
        doorbellPending = 1'b0;
        msiEnable = 1'b1;
        wait_cy(3);
        chk_cnt("gated msi", 16'h0, {12'h0, msiCnt});
        $display("test doorbell actions finished");
        // two events share line a until both clear
        wr(12'h0EC, 4'hF, 32'h0009_0000);
        clr();
        farResetDetected = 1'b1;
        wait_cy(1);
        farResetDetected = 1'b0;
        farPowerChanged = 1'b1;
        wait_cy(1);
        farPowerChanged = 1'b0;
        wait_cy(3);
        rd(12'h0E8);
        chk_reg("far status", 32'h60, rdv);
        chk_cnt("shared assert", 16'h1, astCnt);
        wr(12'h0E8, 4'h1, 32'h20);
        wait_cy(3);
        chk_cnt("one cleared", 16'h0, deaCnt);
        wr(12'h0E8, 4'h1, 32'h40);
        wait_cy(3);
        chk_cnt("all cleared", 16'h1, deaCnt);
        // link up while legacy messages are disabled, then enabled
        clr();
        legacyIrqDisable = 1'b1;
        portALinkUp = 1'b1;
        wait_cy(4);
        chk_cnt("disabled", 16'h0, astCnt);
        rd(12'h0E8);
        chk_reg("link status", 32'h80, rdv);
        legacyIrqDisable = 1'b0;
        wait_cy(3);
        chk_cnt("line d", 16'h1000, astCnt);
        wr(12'h0E8, 4'h1, 32'h80);
        portALinkUp = 1'b0;
        wait_cy(3);
        chk_cnt("line d off", 16'h1000, deaCnt);
        $display("test legacy lines finished");
        // indirect window, this side only
        wr(12'h0F8, 4'hF, 32'hF4);
        rd(12'h0FC);
        chk_reg("ind read", 32'h3, rdv);
        clr();
        wr(12'h0FC, 4'h1, 32'h0);
        wr(12'h0FC, 4'h1, 32'h2);
        chk_reg("ind power_state_field", 32'h0, {30'h0, powerState});
        chk_cnt("modified", 16'h1, {12'h0, modCnt});
        wr(12'h0F8, 4'hF, 32'hFC);
        wr(12'h0FC, 4'hF, 32'hFFFF_FFFF);
        rd(12'h0FC);
        chk_reg("self data", 32'h0, rdv);
        rd(12'h0F8);
        chk_reg("addr kept", 32'hFC, rdv);
        wr(12'h0F8, 4'hF, 32'hF8);
        wr(12'h0FC, 4'hF, 32'h200);
        rd(12'h0F8);
        chk_reg("addr via data", 32'h200, rdv);
        regLockActive = 1'b1;
        wr(12'h0F0, 4'hF, 32'hFFFF_FFFF);
        rd(12'h0F0);
        chk_reg("locked", 32'h0002_0001, rdv);
        $display("test indirect and lock finished");
        // second reset brings every writable field back to zero
        wr(12'h0F4, 4'h1, 32'h3);
        rst_b = 1'b0;
        wait_cy(2);
        chk_reg("reset power_state_field", 32'h0, {30'h0, powerState});
        rst_b = 1'b1;
        wait_cy(1);
        foreach (ROWS[i]) begin
            rd(ROWS[i].adr);
            chk_reg("reset", i < 2 ? 32'h0002_0001 : 32'h0, rdv);
        end
        $display("test reset finished");
        complete_run();
    end
endmodule // ntb_endpoint_intr_pm_cfg_regs_bench
